// file: core/decode_if.sv
// Interface carrying one instruction word to the decoder and its fields back.
// Assumes the executor drives the word and the decoder is purely combinational.
`timescale 1ns/1ps
interface decode_if;
  import trx_pkg::*;
  logic [INSN_W-1:0]    insn;
  op_kind_t             op;
  logic [REG_IDX_W-1:0] a_idx;
  logic [REG_IDX_W-1:0] b_field;
  logic [5:0]           trap_num;
  logic [K_W-1:0]       k_field;

  modport decoder (input insn, output op, a_idx, b_field, trap_num, k_field);
  modport user    (output insn, input op, a_idx, b_field, trap_num, k_field);
endinterface

// file: core/insn_decode.sv
// Combinational instruction decoder for the executor.
// Assumes the instruction word on the interface is stable while it is used.
`timescale 1ns/1ps
module insn_decode import trx_pkg::*; (
  decode_if.decoder d
);

  // Classifies one instruction word by its fixed opcode bits.
  function automatic op_kind_t classify(input logic [INSN_W-1:0] w);
    op_kind_t k;
    k = OP_NONE;
    if (w[15:6] == OPC_TRAP) begin
      k = OP_TRAP;
    end else if (w[15:5] == OPC_TRAP_RETURN_OP) begin
      k = OP_TRAP_RETURN_OP;
    end else if (w[15:5] == OPC_CONTROL_WRITE_OP) begin
      k = OP_CONTROL_WRITE_OP;
    end else if (w[15:10] == OPC_XOR) begin
      k = OP_XOR;
    end else if (w[15:11] == OPC_PREFIX) begin
      k = OP_PREFIX;
    end
    return k;
  endfunction

  // Field extraction; the middle field is a register index or a short immediate.
  always_comb begin
    d.op = classify(d.insn);
  end
  assign d.a_idx    = d.insn[4:0];
  assign d.b_field  = d.insn[9:5];
  assign d.trap_num = d.insn[5:0];
  assign d.k_field  = d.insn[10:0];

endmodule

// file: core/trap_return_xor_execute.sv
// Executor for trap, trap return, control write, prefix and exclusive-OR instructions.
// Assumes an AXI4-Lite master issues instructions and a memory answers vector reads.
//
// Overview of operation
// - A trap copies the old status into the saved status register.
// - A trap clears the interrupt enable bit.
// - A trap decrements the window pointer by one.
// - A trap reads a vector at base plus trap number times four.
// - The fetched vector doubled becomes the new program counter.
// - A trap writes (PC + 2) shifted right once into the link register.
// - A trap is taken even while interrupts are disabled.
// - No delay slot: nothing executes until the handler address is loaded.
// - Trap opcode is bits 15..6, trap number in bits 5..0; flags untouched.
// - Unprefixed exclusive-OR combines destination and source registers.
// - Prefixed exclusive-OR uses prefix value above the five-bit immediate.
// - The sixteen-bit immediate is zero-extended and result written back.
// - Exclusive-OR sets negative from bit 31 and zero; others unchanged.
// - Exclusive-OR opcode bits 15..10; source bits 9..5; destination bits 4..0.
`timescale 1ns/1ps
module trap_return_xor_execute import trx_pkg::*; #(
  parameter logic [DATA_W-1:0] VECTOR_BASE = 32'h0000_0000,
  parameter int unsigned       AXI_ADDR_W  = 8
) (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [DATA_W-1:0]     s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [DATA_W-1:0]          s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output logic                       mem_rd_req,
  output logic [DATA_W-1:0]          mem_addr,
  input  wire logic [DATA_W-1:0]     mem_rdata,
  input  wire logic                  mem_rvalid,
  output logic                       irq_enable
);

  // Parameter checks.
  if (AXI_ADDR_W < 8 || AXI_ADDR_W > 32) begin : g_bad_addr_w
    $error("AXI address width must be 8 to 32 bits.");
  end
  if (VECTOR_BASE[1:0] != 2'b00) begin : g_bad_base
    $error("Vector table base must be word aligned.");
  end

  // Maps a bus address onto a register, refusing misaligned or out-of-range ones.
  function automatic reg_sel_t map_addr(input logic [AXI_ADDR_W-1:0] addr);
    reg_sel_t s;
    s = SEL_NONE;
    if ((addr >> 8) == '0) begin
      case (addr[7:0])
        OFF_INSTR:  s = SEL_INSTR;
        OFF_PC:     s = SEL_PC;
        OFF_STATUS: s = SEL_STATUS;
        OFF_SAVED:  s = SEL_SAVED;
        OFF_KREG:   s = SEL_KREG;
        OFF_RSEL:   s = SEL_RSEL;
        OFF_RDATA:  s = SEL_RDATA;
        OFF_EXEC:   s = SEL_EXEC;
        default:    s = SEL_NONE;
      endcase
    end
    return s;
  endfunction

  // Applies byte strobes to a register word.
  function automatic logic [DATA_W-1:0] merge_bytes(input logic [DATA_W-1:0] old_v,
                                                    input logic [DATA_W-1:0] new_v,
                                                    input logic [3:0]        strb);
    logic [DATA_W-1:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  logic [DATA_W-1:0]     regs [NUM_REGS];
  logic [AXI_ADDR_W-1:0] aw_addr_r;
  logic                  aw_held_r;
  logic [DATA_W-1:0]     w_data_r;
  logic [3:0]            w_strb_r;
  logic                  w_held_r;
  logic [DATA_W-1:0]     pc_r;
  logic [STATUS_W-1:0]   status_r;
  logic [STATUS_W-1:0]   saved_r;
  logic [K_W-1:0]        k_r;
  logic                  pfx_r;
  logic [REG_IDX_W-1:0]  rsel_r;
  exec_state_t           ex_state_r;
  reg_sel_t              sel_w;
  reg_sel_t              sel_r;
  logic                  wr_fire;
  logic                  wr_refused;
  logic                  sw_wr;
  logic                  go;
  logic                  go_trap;
  logic                  go_trap_return_op;
  logic                  go_control_write_op;
  logic                  go_xor;
  logic [DATA_W-1:0]     wr_old;
  logic [DATA_W-1:0]     wr_merged;
  logic [DATA_W-1:0]     rd_word;
  logic [DATA_W-1:0]     a_val;
  logic [DATA_W-1:0]     xor_res;
  logic                  xor_neg;
  logic                  xor_zero;
  logic [DATA_W-1:0]     link_val;
  logic [DATA_W-1:0]     vec_addr_nxt;

  decode_if dif ();

  insn_decode u_dec (
    .d (dif.decoder)
  );

  xor_unit u_xor (
    .a_val   (a_val),
    .b_val   (regs[dif.b_field]),
    .k_val   (k_r),
    .short_imm_field    (dif.b_field),
    .use_imm (pfx_r),
    .result  (xor_res),
    .neg     (xor_neg),
    .zero    (xor_zero)
  );

  // Instruction issue decode; a new instruction is refused while the trap vector is fetched.
  assign dif.insn     = w_data_r[INSN_W-1:0];
  assign sel_w        = map_addr(aw_addr_r);
  assign sel_r        = map_addr(s_axi_araddr);
  assign wr_fire      = aw_held_r && w_held_r && !s_axi_bvalid;
  assign wr_refused   = (sel_w == SEL_NONE) ||
                        ((ex_state_r != EX_IDLE) && (sel_w inside {SEL_INSTR, SEL_PC, SEL_STATUS, SEL_RDATA}));
  assign sw_wr        = wr_fire && !wr_refused;
  assign go           = sw_wr && (sel_w == SEL_INSTR);
  assign go_trap      = go && (dif.op == OP_TRAP);
  assign go_trap_return_op      = go && (dif.op == OP_TRAP_RETURN_OP);
  assign go_control_write_op     = go && (dif.op == OP_CONTROL_WRITE_OP);
  assign go_xor       = go && (dif.op == OP_XOR);
  assign a_val        = regs[dif.a_idx];
  assign link_val     = (pc_r + PC_STEP) >> 1;
  assign vec_addr_nxt = VECTOR_BASE + {24'h000000, dif.trap_num, 2'b00};
  assign irq_enable   = status_r[ST_IE];

  // Old value of the written register, for byte-strobe merging.
  always_comb begin
    unique case (sel_w)
      SEL_PC:     wr_old = pc_r;
      SEL_STATUS: wr_old = {16'h0000, status_r};
      SEL_RSEL:   wr_old = {27'h0, rsel_r};
      SEL_RDATA:  wr_old = regs[rsel_r];
      default:    wr_old = '0;
    endcase
    wr_merged = merge_bytes(wr_old, w_data_r, w_strb_r);
  end

  // Read data mux; reserved bits read as zero.
  always_comb begin
    unique case (sel_r)
      SEL_PC:     rd_word = pc_r;
      SEL_STATUS: rd_word = {16'h0000, status_r};
      SEL_SAVED:  rd_word = {16'h0000, saved_r};
      SEL_KREG:   rd_word = {21'h0, k_r};
      SEL_RSEL:   rd_word = {27'h0, rsel_r};
      SEL_RDATA:  rd_word = regs[rsel_r];
      SEL_EXEC:   rd_word = {30'h0, pfx_r, (ex_state_r == EX_FETCH)};
      default:    rd_word = '0;
    endcase
  end

  // Write address channel: one address held until its response is taken.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b0;
      aw_held_r     <= 1'b0;
      aw_addr_r     <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_held_r     <= 1'b1;
      aw_addr_r     <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      aw_held_r <= 1'b0;
    end else if (!aw_held_r) begin
      s_axi_awready <= 1'b1;
    end
  end

  // Write data channel, taken independently of the address.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_wready <= 1'b0;
      w_held_r     <= 1'b0;
      w_data_r     <= '0;
      w_strb_r     <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_held_r     <= 1'b1;
      w_data_r     <= s_axi_wdata;
      w_strb_r     <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      w_held_r <= 1'b0;
    end else if (!w_held_r) begin
      s_axi_wready <= 1'b1;
    end
  end

  // Write response one cycle after both halves are held.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_refused ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel: data is answered the cycle after the address is taken.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= (sel_r == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // General registers: software access, exclusive-OR result and trap link.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs[i] <= '0;
      end
    end else if (sw_wr && sel_w == SEL_RDATA) begin
      regs[rsel_r] <= wr_merged;
    end else if (go_xor) begin
      regs[dif.a_idx] <= xor_res;
    end else if (go_trap) begin
      regs[LINK_IDX] <= link_val;
    end
  end

  // Register index used by the data window.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rsel_r <= '0;
    end else if (sw_wr && sel_w == SEL_RSEL) begin
      rsel_r <= wr_merged[REG_IDX_W-1:0];
    end
  end

  // Status register updates; the trap leaves condition flags alone.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      status_r <= STATUS_RST;
    end else if (sw_wr && sel_w == SEL_STATUS) begin
      status_r <= wr_merged[STATUS_W-1:0];
    end else if (go_trap) begin
      status_r[ST_IE]                      <= 1'b0;
      status_r[ST_CWP_LSB +: ST_CWP_W]     <= status_r[ST_CWP_LSB +: ST_CWP_W] - CWP_STEP;
      status_r[ST_IRQ_PRIORITY_FIELD_LSB +: ST_IRQ_PRIORITY_FIELD_W]   <= dif.trap_num;
    end else if (go_trap_return_op) begin
      status_r <= saved_r;
    end else if (go_control_write_op && (!pfx_r || k_r == CTL_SEL_STATUS)) begin
      status_r <= a_val[STATUS_W-1:0];
    end else if (go_xor) begin
      status_r[ST_FLAG_N] <= xor_neg;
      status_r[ST_FLAG_Z] <= xor_zero;
    end
  end

  // Saved status: taken by a trap or written through a prefixed control write.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      saved_r <= STATUS_RST;
    end else if (go_trap) begin
      saved_r <= status_r;
    end else if (go_control_write_op && pfx_r && k_r == CTL_SEL_SAVED) begin
      saved_r <= a_val[STATUS_W-1:0];
    end
  end

  // Prefix state lasts for exactly the next instruction.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pfx_r <= 1'b0;
      k_r   <= '0;
    end else if (go) begin
      pfx_r <= (dif.op == OP_PREFIX);
      if (dif.op == OP_PREFIX) begin
        k_r <= dif.k_field;
      end
    end
  end

  // Program counter: steps by two, or jumps on trap vector and trap return.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pc_r <= PC_RST;
    end else if (sw_wr && sel_w == SEL_PC) begin
      pc_r <= wr_merged;
    end else if (ex_state_r == EX_FETCH && mem_rvalid) begin
      pc_r <= {mem_rdata[DATA_W-2:0], 1'b0};
    end else if (go_trap_return_op) begin
      pc_r <= {a_val[DATA_W-2:0], 1'b0};
    end else if (go && !go_trap) begin
      pc_r <= pc_r + PC_STEP;
    end
  end

  // Vector fetch sequencer; request held until the memory answers.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ex_state_r <= EX_IDLE;
      mem_rd_req <= 1'b0;
      mem_addr   <= '0;
    end else begin
      unique case (ex_state_r)
        EX_IDLE: begin
          if (go_trap) begin
            ex_state_r <= EX_FETCH;
            mem_rd_req <= 1'b1;
            mem_addr   <= vec_addr_nxt;
          end
        end
        EX_FETCH: begin
          if (mem_rvalid) begin
            ex_state_r <= EX_IDLE;
            mem_rd_req <= 1'b0;
          end
        end
      endcase
    end
  end

  // Checks on the executed behaviour.
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_trap_issue;
    go_trap;
  endsequence

  sequence s_fetch_wait;
    (ex_state_r == EX_FETCH) && mem_rd_req;
  endsequence

  a_trap_saved: assert property (s_trap_issue |=> saved_r == $past(status_r))
    else $error("Trap did not save the old status.");
  a_trap_ie_off: assert property (s_trap_issue |=> !status_r[ST_IE])
    else $error("Trap left interrupts enabled.");
  a_trap_cwp: assert property (s_trap_issue |=>
      status_r[ST_CWP_LSB +: ST_CWP_W] == $past(status_r[ST_CWP_LSB +: ST_CWP_W]) - CWP_STEP)
    else $error("Trap did not step the window pointer down by one.");
  a_vec_addr: assert property (s_trap_issue |=> s_fetch_wait ##0 mem_addr == $past(vec_addr_nxt))
    else $error("Vector read address is wrong.");
  a_vec_to_pc: assert property ((ex_state_r == EX_FETCH && mem_rvalid) |=>
      pc_r == {$past(mem_rdata[DATA_W-2:0]), 1'b0} && ex_state_r == EX_IDLE)
    else $error("Handler address not loaded as doubled vector.");
  a_link_value: assert property (s_trap_issue |=> regs[LINK_IDX] == $past(link_val))
    else $error("Link register does not hold the halved return address.");
  a_trap_no_ie: assert property ((go_trap && !status_r[ST_IE]) |=> s_fetch_wait)
    else $error("Trap not taken while interrupts were disabled.");
  a_no_slot: assert property ((ex_state_r == EX_FETCH) |-> !go && $stable(pc_r))
    else $error("An instruction ran before the trap handler.");
  a_trap_irq_priority_field: assert property (s_trap_issue |=>
      status_r[ST_IRQ_PRIORITY_FIELD_LSB +: ST_IRQ_PRIORITY_FIELD_W] == $past(dif.trap_num) && $stable(status_r[3:0]))
    else $error("Trap priority or flags wrong after trap.");
  a_xor_write: assert property (go_xor |=> regs[$past(dif.a_idx)] == $past(xor_res))
    else $error("Exclusive-OR result not written to destination.");
  a_xor_flags: assert property (go_xor |=> status_r[ST_FLAG_N] == regs[$past(dif.a_idx)][DATA_W-1] &&
      status_r[ST_FLAG_Z] == (regs[$past(dif.a_idx)] == '0) &&
      $stable(status_r[ST_FLAG_V]) && $stable(status_r[ST_FLAG_C]))
    else $error("Exclusive-OR flags wrong.");
  a_trap_return_op_return: assert property (go_trap_return_op |=> pc_r == {$past(a_val[DATA_W-2:0]), 1'b0} &&
      status_r == $past(saved_r))
    else $error("Trap return did not restore PC and status.");

endmodule

// file: core/trx_pkg.sv
// Shared constants and types for the trap, trap-return and exclusive-OR executor.
// Assumes a single 125 MHz core clock and a 32-bit AXI4-Lite register bus.
package trx_pkg;

  // Data path and instruction widths.
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned INSN_W    = 16;
  localparam int unsigned REG_IDX_W = 5;
  localparam int unsigned NUM_REGS  = 32;
  localparam int unsigned STATUS_W  = 16;
  localparam int unsigned K_W       = 11;

  // Register byte offsets on the bus.
  localparam logic [7:0] OFF_INSTR  = 8'h00;
  localparam logic [7:0] OFF_PC     = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_SAVED  = 8'h0c;
  localparam logic [7:0] OFF_KREG   = 8'h10;
  localparam logic [7:0] OFF_RSEL   = 8'h14;
  localparam logic [7:0] OFF_RDATA  = 8'h18;
  localparam logic [7:0] OFF_EXEC   = 8'h1c;

  // Status register field layout.
  localparam int unsigned ST_FLAG_C   = 0;
  localparam int unsigned ST_FLAG_Z   = 1;
  localparam int unsigned ST_FLAG_V   = 2;
  localparam int unsigned ST_FLAG_N   = 3;
  localparam int unsigned ST_IRQ_PRIORITY_FIELD_LSB = 4;
  localparam int unsigned ST_IRQ_PRIORITY_FIELD_W   = 6;
  localparam int unsigned ST_CWP_LSB  = 10;
  localparam int unsigned ST_CWP_W    = 5;
  localparam int unsigned ST_IE       = 15;

  // Reset values and fixed steps.
  localparam logic [STATUS_W-1:0] STATUS_RST = 16'h0000;
  localparam logic [DATA_W-1:0]   PC_RST     = 32'h0000_0000;
  localparam logic [DATA_W-1:0]   PC_STEP    = 32'h0000_0002;
  localparam logic [ST_CWP_W-1:0] CWP_STEP   = 5'h01;

  // Instruction encodings.
  localparam logic [9:0]  OPC_TRAP   = 10'h1e4;
  localparam logic [10:0] OPC_TRAP_RETURN_OP   = 11'h3ee;
  localparam logic [10:0] OPC_CONTROL_WRITE_OP  = 11'h3f8;
  localparam logic [5:0]  OPC_XOR    = 6'h11;
  localparam logic [4:0]  OPC_PREFIX = 5'h13;
  localparam logic [REG_IDX_W-1:0] LINK_IDX = 5'h0f;

  // Control register selectors carried by the prefix value.
  localparam logic [K_W-1:0] CTL_SEL_STATUS = 11'h000;
  localparam logic [K_W-1:0] CTL_SEL_SAVED  = 11'h001;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    OP_NONE   = 3'b000,
    OP_TRAP   = 3'b001,
    OP_TRAP_RETURN_OP   = 3'b010,
    OP_CONTROL_WRITE_OP  = 3'b011,
    OP_XOR    = 3'b100,
    OP_PREFIX = 3'b101
  } op_kind_t;

  typedef enum logic [0:0] {
    EX_IDLE  = 1'b0,
    EX_FETCH = 1'b1
  } exec_state_t;

  typedef enum logic [3:0] {
    SEL_INSTR  = 4'h0,
    SEL_PC     = 4'h1,
    SEL_STATUS = 4'h2,
    SEL_SAVED  = 4'h3,
    SEL_KREG   = 4'h4,
    SEL_RSEL   = 4'h5,
    SEL_RDATA  = 4'h6,
    SEL_EXEC   = 4'h7,
    SEL_NONE   = 4'hf
  } reg_sel_t;

endpackage

// file: core/xor_unit.sv
// Exclusive-OR unit with negative and zero flag outputs.
// Assumes the caller chooses between the register and prefixed immediate operand.
`timescale 1ns/1ps
module xor_unit import trx_pkg::*; (
  input  wire logic [DATA_W-1:0]    a_val,
  input  wire logic [DATA_W-1:0]    b_val,
  input  wire logic [K_W-1:0]       k_val,
  input  wire logic [REG_IDX_W-1:0] short_imm_field,
  input  wire logic                 use_imm,
  output logic      [DATA_W-1:0]    result,
  output logic                      neg,
  output logic                      zero
);

  logic [DATA_W-1:0] operand;

  // Second operand is the register or the zero-extended prefix immediate.
  always_comb begin
    if (use_imm) begin
      operand = {16'h0000, k_val, short_imm_field};
    end else begin
      operand = b_val;
    end
    result = a_val ^ operand;
    neg    = result[DATA_W-1];
    zero   = (result == '0);
  end

endmodule

// file: tb/trap_return_xor_execute_test.sv
// Bench for the trap, trap-return and exclusive-OR executor over AXI4-Lite.
// Assumes the vector memory model answers the trap vector reads.
`timescale 1ns/1ps
module trap_return_xor_execute_test;
  import trx_pkg::*;
  logic        clk = 1'b0, sys_rst = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, mem_addr, mem_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        mem_rd_req, mem_rvalid, irq_enable;
  int          fails = 0, check_count = 0;
  trap_return_xor_execute #(.VECTOR_BASE(32'h0000_0100)) uut (.clk, .sys_rst, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mem_rd_req, .mem_addr,
    .mem_rdata, .mem_rvalid, .irq_enable);
  vec_mem mem (.clk, .mem_rd_req, .mem_addr, .mem_rdata, .mem_rvalid);
  // Free-running 8 ns clock.
  initial forever #4 clk = ~clk;
  // Compare and count.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One AXI write; each channel drops once taken, response checked.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
  endtask
  // One AXI read with data and response checked.
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, exp);
    chk(s_axi_rresp, er);
  endtask
  // General register access through the select register.
  task automatic setr(input logic [4:0] i, input logic [31:0] v);
    wr(OFF_RSEL, {27'h0, i}, RESP_OKAY);
    wr(OFF_RDATA, v, RESP_OKAY);
  endtask
  task automatic getr(input logic [4:0] i, input logic [31:0] exp);
    wr(OFF_RSEL, {27'h0, i}, RESP_OKAY);
    rd(OFF_RDATA, exp, RESP_OKAY);
  endtask
  task automatic print_verdict();
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Hang guard; the tests need far fewer than 5000 cycles.
  initial begin
    #40000;
    fails++;
    print_verdict();
  end
  // Test sequence.
  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    setr(5'd1, 32'h8000_0005);
    setr(5'd2, 32'h8000_0005);
    setr(5'd3, 32'h8000_0000);
    wr(OFF_STATUS, 32'h0000_0005, RESP_OKAY);
    wr(OFF_INSTR, 32'h0, RESP_OKAY);
    wr(OFF_INSTR, 32'h0000_4441, RESP_OKAY);
    getr(5'd1, 32'h0);
    rd(OFF_STATUS, 32'h0000_0007, RESP_OKAY);
    wr(OFF_INSTR, 32'h0000_4461, RESP_OKAY);
    getr(5'd1, 32'h8000_0000);
    rd(OFF_STATUS, 32'h0000_000d, RESP_OKAY);
    $display("xor_reg done");
    wr(OFF_INSTR, 32'h0000_9fff, RESP_OKAY);
    wr(OFF_INSTR, 32'h0000_47e1, RESP_OKAY);
    getr(5'd1, 32'h8000_ffff);
    wr(OFF_INSTR, 32'h0000_4441, RESP_OKAY);
    getr(5'd1, 32'h0000_fffa);
    rd(OFF_STATUS, 32'h0000_0005, RESP_OKAY);
    $display("xor_imm done");
    wr(OFF_STATUS, 32'h0000_8c05, RESP_OKAY);
    wr(OFF_INSTR, 32'h0, RESP_OKAY);
    wr(OFF_PC, 32'h0000_0020, RESP_OKAY);
    wr(OFF_INSTR, 32'h0000_7905, RESP_OKAY);
    wr(OFF_PC, 32'h0000_0100, RESP_SLVERR);
    chk(mem_addr, 32'h0000_0114);
    chk({31'h0, irq_enable}, 32'h0);
    while (mem_rd_req) @(posedge clk);
    rd(OFF_PC, 32'h0000_02a8, RESP_OKAY);
    rd(OFF_SAVED, 32'h0000_8c05, RESP_OKAY);
    rd(OFF_STATUS, 32'h0000_0855, RESP_OKAY);
    getr(LINK_IDX, 32'h0000_0011);
    $display("trap done");
    wr(OFF_INSTR, 32'h0000_7dcf, RESP_OKAY);
    rd(OFF_PC, 32'h0000_0022, RESP_OKAY);
    rd(OFF_STATUS, 32'h0000_8c05, RESP_OKAY);
    chk({31'h0, irq_enable}, 32'h1);
    rd(8'h20, 32'h0, RESP_SLVERR);
    wr(8'h20, 32'h0, RESP_SLVERR);
    $display("trap_return_op done");
    setr(5'd4, 32'h0000_0c0a);
    wr(OFF_INSTR, 32'h0000_7f04, RESP_OKAY);
    wr(OFF_INSTR, 32'h0, RESP_OKAY);
    rd(OFF_STATUS, 32'h0000_0c0a, RESP_OKAY);
    chk({31'h0, irq_enable}, 32'h0);
    wr(OFF_INSTR, 32'h0000_9801, RESP_OKAY);
    wr(OFF_INSTR, 32'h0000_7f02, RESP_OKAY);
    rd(OFF_SAVED, 32'h0000_0005, RESP_OKAY);
    rd(OFF_STATUS, 32'h0000_0c0a, RESP_OKAY);
    $display("control_write_op done");
    wr(OFF_PC, 32'h0000_0040, RESP_OKAY);
    wr(OFF_INSTR, 32'h0000_7902, RESP_OKAY);
    chk({31'h0, mem_rd_req}, 32'h1);
    chk(mem_addr, 32'h0000_0108);
    while (mem_rd_req) @(posedge clk);
    rd(OFF_PC, 32'h0000_0290, RESP_OKAY);
    rd(OFF_STATUS, 32'h0000_082a, RESP_OKAY);
    rd(OFF_SAVED, 32'h0000_0c0a, RESP_OKAY);
    getr(LINK_IDX, 32'h0000_0021);
    $display("trap_no_ie done");
    print_verdict();
  end
endmodule

// file: tb/vec_mem.sv
// Vector memory model that answers trap vector reads after a set delay.
// Assumes a request holds until answered and only one is pending at a time.
`timescale 1ns/1ps
module vec_mem #(
  parameter int DLY = 12
) (
  input  wire logic        clk,
  input  wire logic        mem_rd_req,
  input  wire logic [31:0] mem_addr,
  output logic      [31:0] mem_rdata = 32'h5a5a_5a5a,
  output logic             mem_rvalid = 1'b0
);
  int cnt_r = 0;
  // Answer with the address plus 0x40; outside an answer the data toggles.
  always @(posedge clk) begin
    mem_rvalid <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_rd_req && !mem_rvalid) begin
      cnt_r <= cnt_r + 1;
      if (cnt_r == DLY) begin
        cnt_r <= 0;
        mem_rvalid <= 1'b1;
        mem_rdata <= mem_addr + 32'h0000_0040;
      end
    end
  end
endmodule
